// ### core/pep_pkg.sv
// Package with register map, field layouts and reset values of the block.
//
// Behaviour
// - First mask register bits 6..0: seven read/write masks, zero at reset.
// - Mask bit one lets its source request through; zero blocks it.
// - Second mask register bits 7..1: seven read/write masks, zero at reset.
// - USB mask bit two enables the USB request; others encode alike.
// - Bit 7 of first registers, bit 0 of second, ignore writes, read zero.
// - First level register bits 6..0 select level per source, one at reset.
// - Second level register bits 7..1 select level per source, one at reset.
// - Level bit one routes source to high level, zero to low level.
// - Level bits act only while priority enable is set; else ignored.
// - Priority enable sits in the reset cause register beside cause flags.
// - Without priority levels, group enable must be set to pass requests.
`default_nettype none

package pep_pkg;

	// ********************************************************************
	// Register offsets (byte addresses, one aligned word each)
	// ********************************************************************
	localparam logic [7:0] OFF_MASK_1  = 8'h00;
	localparam logic [7:0] OFF_MASK_2  = 8'h04;
	localparam logic [7:0] OFF_LEVEL_1 = 8'h08;
	localparam logic [7:0] OFF_LEVEL_2 = 8'h0c;
	localparam logic [7:0] OFF_RCS     = 8'h10;
	localparam logic [7:0] OFF_CTRL    = 8'h14;
	localparam logic [7:0] OFF_FLAGS   = 8'h18;
	localparam logic [7:0] OFF_IRQ_EN  = 8'h1c;

	// ********************************************************************
	// Field layouts
	// ********************************************************************
	localparam logic [7:0] IMPL_1 = 8'h7f;
	localparam logic [7:0] IMPL_2 = 8'hfe;
	// Combined sixteen-bit layout: second group above, first group below.
	localparam logic [15:0] IMPL_ALL = {IMPL_2, IMPL_1};
	localparam int USB_BIT        = 2;
	localparam int PRIO_ON_BIT    = 7;
	localparam int CAUSE_W        = 7;
	localparam int GROUP_EN_BIT   = 0;

	// ********************************************************************
	// Values after reset
	// ********************************************************************
	localparam logic [7:0]  MASK_1_RST  = 8'h00;
	localparam logic [7:0]  MASK_2_RST  = 8'h00;
	localparam logic [7:0]  LEVEL_1_RST = 8'h7f;
	localparam logic [7:0]  LEVEL_2_RST = 8'hfe;
	localparam logic        PRIO_RST    = 1'b0;
	localparam logic        GROUP_RST   = 1'b0;
	localparam logic [15:0] FLAGS_RST   = 16'h0000;
	localparam logic [15:0] IRQ_EN_RST  = 16'h0000;

endpackage

`default_nettype wire

// ### core/pep_route.sv
// Gating and level routing of the peripheral interrupt requests.
`default_nettype none

module pep_route
	import pep_pkg::*;
(
	input  wire logic [15:0] flags,
	input  wire logic [15:0] masks,
	input  wire logic [15:0] levels,
	input  wire logic        prio_on,
	input  wire logic        group_en,
	output logic      [15:0] high_req,
	output logic      [15:0] low_req
);

	logic [15:0] req;
	logic        gate;

	always_comb begin
		// Group enable only matters in single level mode.
		gate = prio_on | group_en;
		req = flags & masks & IMPL_ALL & {16{gate}};
		if (prio_on) begin
			high_req = req & levels;
			low_req  = req & ~levels;
		end else begin
			// Single level mode sends every request to the high output.
			high_req = req;
			low_req  = 16'h0000;
		end
	end

endmodule

`default_nettype wire

// ### core/pep_top.sv
// Peripheral interrupt mask and level register bank with Avalon-MM slave.
`default_nettype none

module pep_top
	import pep_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire logic [ADDR_W-1:0]  avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic      [31:0]        avs_readdata,
	output logic                    avs_waitrequest,
	input  wire logic [15:0]        event_in,
	input  wire logic [CAUSE_W-1:0] reset_cause_flags,
	output logic      [15:0]        high_pending,
	output logic      [15:0]        low_pending,
	output logic                    irq_high,
	output logic                    irq_low,
	output logic                    irq
);

	// ********************************************************************
	// Parameter check
	// ********************************************************************
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
		$error("pep_top: ADDR_W must lie between 5 and 8");
	end

	// ********************************************************************
	// Bus decode
	// ********************************************************************
	logic [7:0]  addr8;
	logic        wr_acc;
	logic        rd_take;
	logic [7:0]  periph_irq_mask_1;
	logic [7:0]  periph_irq_mask_2;
	logic [7:0]  periph_irq_level_1;
	logic [7:0]  periph_irq_level_2;
	logic        priority_levels_on;
	logic        periph_group_enable;
	logic [15:0] flags;
	logic [15:0] irq_en;
	logic [15:0] next_flags;
	logic [15:0] high_req;
	logic [15:0] low_req;
	logic [31:0] next_readdata;

	assign addr8 = 8'(avs_address);
	// A write lands on the edge where waitrequest is seen low.
	assign wr_acc = avs_write && !avs_waitrequest;
	// Read data is captured one edge early so it stands when sampled.
	assign rd_take = avs_read && avs_waitrequest;

	function automatic logic wr_hit(input logic [7:0] a,
	                                input logic [7:0] off,
	                                input logic       acc,
	                                input logic       lane);
		wr_hit = acc && lane && (a == off);
	endfunction

	// ********************************************************************
	// Waitrequest: one wait cycle for every access
	// ********************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ********************************************************************
	// Mask and level registers
	// ********************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_irq_mask_1 <= MASK_1_RST;
		end else if (wr_hit(addr8, OFF_MASK_1, wr_acc, avs_byteenable[0])) begin
			periph_irq_mask_1 <= avs_writedata[7:0] & IMPL_1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_irq_mask_2 <= MASK_2_RST;
		end else if (wr_hit(addr8, OFF_MASK_2, wr_acc, avs_byteenable[0])) begin
			periph_irq_mask_2 <= avs_writedata[7:0] & IMPL_2;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_irq_level_1 <= LEVEL_1_RST;
		end else if (wr_hit(addr8, OFF_LEVEL_1, wr_acc, avs_byteenable[0])) begin
			periph_irq_level_1 <= avs_writedata[7:0] & IMPL_1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_irq_level_2 <= LEVEL_2_RST;
		end else if (wr_hit(addr8, OFF_LEVEL_2, wr_acc, avs_byteenable[0])) begin
			periph_irq_level_2 <= avs_writedata[7:0] & IMPL_2;
		end
	end

	// ********************************************************************
	// Priority enable and group enable
	// ********************************************************************
	// The cause flags next to the priority enable are kept by their owner.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			priority_levels_on <= PRIO_RST;
		end else if (wr_hit(addr8, OFF_RCS, wr_acc, avs_byteenable[0])) begin
			priority_levels_on <= avs_writedata[PRIO_ON_BIT];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periph_group_enable <= GROUP_RST;
		end else if (wr_hit(addr8, OFF_CTRL, wr_acc, avs_byteenable[0])) begin
			periph_group_enable <= avs_writedata[GROUP_EN_BIT];
		end
	end

	// ********************************************************************
	// Request flags: set by events, cleared by writing one
	// ********************************************************************
	always_comb begin
		next_flags = flags;
		if (wr_hit(addr8, OFF_FLAGS, wr_acc, avs_byteenable[0])) begin
			next_flags[7:0] = next_flags[7:0] & ~avs_writedata[7:0];
		end
		if (wr_hit(addr8, OFF_FLAGS, wr_acc, avs_byteenable[1])) begin
			next_flags[15:8] = next_flags[15:8] & ~avs_writedata[15:8];
		end
		// The set is applied last so an event in the clear cycle survives.
		next_flags = (next_flags | event_in) & IMPL_ALL;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags <= FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_en <= IRQ_EN_RST;
		end else begin
			if (wr_hit(addr8, OFF_IRQ_EN, wr_acc, avs_byteenable[0])) begin
				irq_en[7:0] <= avs_writedata[7:0] & IMPL_1;
			end
			if (wr_hit(addr8, OFF_IRQ_EN, wr_acc, avs_byteenable[1])) begin
				irq_en[15:8] <= avs_writedata[15:8] & IMPL_2;
			end
		end
	end

	// ********************************************************************
	// Read path
	// ********************************************************************
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (addr8)
			OFF_MASK_1:  next_readdata[7:0] = periph_irq_mask_1;
			OFF_MASK_2:  next_readdata[7:0] = periph_irq_mask_2;
			OFF_LEVEL_1: next_readdata[7:0] = periph_irq_level_1;
			OFF_LEVEL_2: next_readdata[7:0] = periph_irq_level_2;
			OFF_RCS: begin
				next_readdata[PRIO_ON_BIT] = priority_levels_on;
				next_readdata[CAUSE_W-1:0] = reset_cause_flags;
			end
			OFF_CTRL:    next_readdata[GROUP_EN_BIT] = periph_group_enable;
			OFF_FLAGS:   next_readdata[15:0] = flags;
			OFF_IRQ_EN:  next_readdata[15:0] = irq_en;
			default:     next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			avs_readdata <= next_readdata;
		end
	end

	// ********************************************************************
	// Request routing
	// ********************************************************************
	pep_route u_route (
		.flags    (flags),
		.masks    ({periph_irq_mask_2, periph_irq_mask_1}),
		.levels   ({periph_irq_level_2, periph_irq_level_1}),
		.prio_on  (priority_levels_on),
		.group_en (periph_group_enable),
		.high_req (high_req),
		.low_req  (low_req)
	);

	// The routed outputs are registered, so they trail the flags by one cycle.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			high_pending <= 16'h0000;
			low_pending  <= 16'h0000;
			irq_high     <= 1'b0;
			irq_low      <= 1'b0;
		end else begin
			high_pending <= high_req;
			low_pending  <= low_req;
			irq_high     <= |high_req;
			irq_low      <= |low_req;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flags & irq_en);
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	a_mask1_write: assert property (
		wr_hit(addr8, OFF_MASK_1, wr_acc, avs_byteenable[0])
		|=> periph_irq_mask_1 == ($past(avs_writedata[7:0]) & 8'h7f))
		else $error("mask 1 write not stored");

	a_level2_write: assert property (
		wr_hit(addr8, OFF_LEVEL_2, wr_acc, avs_byteenable[0])
		|=> periph_irq_level_2 == ($past(avs_writedata[7:0]) & 8'hfe))
		else $error("level 2 write not stored");

	a_unimpl_zero: assert property (
		!periph_irq_mask_1[7] && !periph_irq_mask_2[0]
		&& !periph_irq_level_1[7] && !periph_irq_level_2[0])
		else $error("unimplemented bit set");

	a_masked_block: assert property (
		((flags & {periph_irq_mask_2, periph_irq_mask_1}) == 16'h0000)
		|=> !irq_high && !irq_low)
		else $error("masked request reached an output");

	a_usb_pass: assert property (
		flags[8 + USB_BIT] && periph_irq_mask_2[USB_BIT]
		&& (priority_levels_on || periph_group_enable)
		&& (!priority_levels_on || periph_irq_level_2[USB_BIT])
		|=> irq_high && high_pending[8 + USB_BIT])
		else $error("enabled usb request lost");

	a_low_route: assert property (
		priority_levels_on
		&& |(flags & {periph_irq_mask_2, periph_irq_mask_1}
		     & ~{periph_irq_level_2, periph_irq_level_1})
		|=> irq_low)
		else $error("low level request not routed low");

	a_single_level: assert property (
		!priority_levels_on |=> !irq_low)
		else $error("low output active without priority levels");

	a_group_gate: assert property (
		!priority_levels_on && !periph_group_enable |=> !irq_high)
		else $error("request passed with group disabled");

	a_read_mask2: assert property (
		rd_take && addr8 == OFF_MASK_2
		|=> !avs_waitrequest && avs_readdata == {24'h0, $past(periph_irq_mask_2)})
		else $error("mask 2 read back wrong");

	a_flag_hold: assert property (
		flags[0] && !wr_hit(addr8, OFF_FLAGS, wr_acc, avs_byteenable[0])
		|=> flags[0])
		else $error("flag cleared by hardware");

	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
		|-> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest timing wrong");

	c_high_irq: cover property (priority_levels_on && irq_high);
	c_low_irq: cover property (irq_low ##1 !irq_low);
	c_flag_clear: cover property (flags[1] ##1 !flags[1]);
	c_set_on_clear: cover property (
		wr_hit(addr8, OFF_FLAGS, wr_acc, avs_byteenable[0])
		&& avs_writedata[0] && event_in[0]);

endmodule

`default_nettype wire

// ### testbench/pep_partner.sv
// Peripheral event source model driving the event inputs of the block.
`default_nettype none

module pep_partner (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        fire_go,
	input  wire logic [15:0] fire_bits,
	input  wire logic [1:0]  fire_len,
	output logic      [15:0] event_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] left;

	// A slow source holds its event up to three cycles, a prompt one only
	// one. Flags are sticky, so the flag is set on the same edge either way.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			left     <= 2'h0;
			event_in <= 16'h0000;
		end else if (fire_go) begin
			left     <= fire_len - 2'h1;
			event_in <= fire_bits;
		end else if (left != 2'h0) begin
			left <= left - 2'h1;
		end else begin
			event_in <= 16'h0000;
		end
	end
endmodule

`default_nettype wire

// ### testbench/pep_top_tb.sv
// Self-checking bench for the peripheral interrupt mask and level bank.
`default_nettype none

module pep_top_tb
	import pep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [15:0] event_in;
	logic [6:0]  reset_cause_flags = 7'h00;
	logic [15:0] high_pending;
	logic [15:0] low_pending;
	logic        irq_high;
	logic        irq_low;
	logic        irq;
	logic        fire_go = 1'b0;
	logic [15:0] fire_bits = 16'h0;
	logic [1:0]  fire_len = 2'h1;
	logic [7:0]  offs [4] = '{OFF_MASK_1, OFF_MASK_2, OFF_LEVEL_1, OFF_LEVEL_2};
	logic [7:0]  impl [4] = '{IMPL_1, IMPL_2, IMPL_1, IMPL_2};
	logic [7:0]  rv [4];
	logic [15:0] f;
	logic [15:0] ie;
	logic        p;
	logic        g;
	logic [31:0] rq [$];
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;

	pep_top #(.ADDR_W(8)) u_pep_top (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .event_in(event_in),
		.reset_cause_flags(reset_cause_flags),
		.high_pending(high_pending), .low_pending(low_pending),
		.irq_high(irq_high), .irq_low(irq_low), .irq(irq));

	pep_partner u_pep_partner (.mclk(mclk), .resetn(resetn),
		.fire_go(fire_go), .fire_bits(fire_bits), .fire_len(fire_len),
		.event_in(event_in));

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	// ****************************************************************
	// Reporting and comparison
	// ****************************************************************
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_out(input logic [34:0] got, input logic [34:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The hang guard must outlast the longest sequence by a wide margin.
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	// Read data stand at the edge where waitrequest is sampled low.
	always @(posedge mclk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			cmp_rd(avs_readdata, rq.pop_front());
		end
	end

	// ****************************************************************
	// Bus and event drivers
	// ****************************************************************
	task automatic bus(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be, input logic rd_n_wr);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= rd_n_wr;
		avs_write <= !rd_n_wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		bus(a, d, be, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(a, 32'h0, 4'hf, 1'b1);
	endtask

	task automatic set_reg(input int i, input logic [7:0] d);
		wr(offs[i], {24'h0, d}, 4'h1);
		rv[i] = d & impl[i];
	endtask

	task automatic fire(input logic [15:0] b);
		@(posedge mclk);
		fire_bits <= b;
		fire_len <= 2'($urandom_range(3, 1));
		fire_go <= 1'b1;
		@(posedge mclk);
		fire_go <= 1'b0;
		f = f | (b & IMPL_ALL);
	endtask

	task automatic clr(input logic [15:0] b);
		wr(OFF_FLAGS, {16'h0, b}, 4'h3);
		f = f & ~b;
	endtask

	function automatic logic [34:0] exp_out();
		logic [15:0] gt;
		logic [15:0] hi;
		logic [15:0] lo;
		gt = f & {rv[1], rv[0]};
		hi = p ? (gt & {rv[3], rv[2]}) : (g ? gt : 16'h0);
		lo = p ? (gt & ~{rv[3], rv[2]}) : 16'h0;
		return {hi, lo, |hi, |lo, |(f & ie)};
	endfunction

	task automatic chk_out();
		repeat (4) @(posedge mclk);
		cmp_out({high_pending, low_pending, irq_high, irq_low, irq}, exp_out());
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(52));
		rv = '{MASK_1_RST, MASK_2_RST, LEVEL_1_RST, LEVEL_2_RST};
		f = 16'h0;
		ie = 16'h0;
		p = 1'b0;
		g = 1'b0;
		repeat (16) @(posedge mclk);
		reset_cause_flags <= 7'($urandom);
		resetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(offs[i], {24'h0, rv[i]});
		end
		rd(OFF_RCS, {24'h0, PRIO_RST, reset_cause_flags});
		rd(OFF_CTRL, {31'h0, GROUP_RST});
		rd(OFF_FLAGS, {16'h0, FLAGS_RST});
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 4; k++) begin
				set_reg(i, (k == 0) ? 8'hff : 8'($urandom));
				rd(offs[i], {24'h0, rv[i]});
			end
			wr(offs[i], {24'h0, ~rv[i]}, 4'he);
			rd(offs[i], {24'h0, rv[i]});
		end
		wr(8'h20, 32'hff, 4'hf);
		rd(8'h20, 32'h0);
		for (int j = 0; j < 8; j++) begin
			p = j[1];
			g = j[0];
			wr(OFF_RCS, {24'h0, p, 7'h0}, 4'h1);
			rd(OFF_RCS, {24'h0, p, reset_cause_flags});
			wr(OFF_CTRL, {31'h0, g}, 4'h1);
			for (int i = 0; i < 4; i++) begin
				set_reg(i, 8'($urandom));
			end
			clr(16'hffff);
			fire(16'($urandom));
			chk_out();
		end
		// Only the USB source is unmasked here; then only it is masked in the second register, the first stays all masked.
		p = 1'b0;
		g = 1'b1;
		wr(OFF_RCS, 32'h0, 4'h1);
		set_reg(0, 8'h00);
		set_reg(1, 8'h01 << USB_BIT);
		clr(16'hffff);
		fire(16'hffff);
		chk_out();
		set_reg(1, ~(8'h01 << USB_BIT));
		chk_out();
		wr(OFF_IRQ_EN, 32'hffff, 4'h3);
		ie = 16'hffff;
		chk_out();
		wr(OFF_IRQ_EN, 32'h0, 4'h3);
		ie = 16'h0;
		chk_out();
		wr(OFF_IRQ_EN, 32'hffff, 4'h3);
		ie = 16'hffff;
		clr(16'h0400);
		chk_out();
		clr(16'hffff);
		chk_out();
		rd(OFF_FLAGS, 32'h0);
		// The last read is compared at its own completing edge, so let it pass.
		repeat (2) @(posedge mclk);
		if (rq.size() != 0) begin
			fails++;
		end
		report_and_stop();
	end
endmodule

`default_nettype wire
